//--- design/four_port_parallel_io.sv
/*
 * Four-port parallel I/O bank: data latches, direction registers, pin
 * drivers, read-back, keyscan pull-up and interrupt request, and the
 * takeover of pins by the serial port and the analog converter.
 * Assumes pins arrive asynchronously; the serial port, converter and
 * mask option settings are driven by logic on the same clock.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// Functional notes
// - reset clears directions, keeps data latches
// - data latches have no reset value
// - direction bit one drives, zero floats
// - read gives latch for outputs, pin otherwise
// - data writes always update the latch
// - direction registers read back as written, unimplemented bits zero
// - first port eight pins, offsets 0/4
// - second port bits five to seven
// - third port eight pins, offsets 2/6
// - fourth port bidir bit5, input bit7
// - fourth input pin always readable
// - keyscan option adds pull-up and interrupt
// - keyscan interrupt behaves like external request
// - serial enable hands second port to serial
// - second port registers stay accessible, serial modifies
// - serial out bit5, in bit6, clock bit7
// - third port pins 3-7 shared with converter
module four_port_parallel_io (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// Register port
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	// First port pins
	input wire logic [7:0] FIRST_PORT_PINS_IN,
	output logic [7:0] FIRST_PORT_PINS_OUT,
	output logic [7:0] FIRST_PORT_PINS_OE_OUT,
	output logic [7:0] FIRST_PORT_PULLUP_OUT,
	// Second port pins, bits 7:5 used
	input wire logic [7:0] SECOND_PORT_PINS_IN,
	output logic [7:0] SECOND_PORT_PINS_OUT,
	output logic [7:0] SECOND_PORT_PINS_OE_OUT,
	// Third port pins
	input wire logic [7:0] THIRD_PORT_PINS_IN,
	output logic [7:0] THIRD_PORT_PINS_OUT,
	output logic [7:0] THIRD_PORT_PINS_OE_OUT,
	// Fourth port pins
	input wire logic FOURTH_PORT_BIDIR_PIN_IN,
	output logic FOURTH_PORT_BIDIR_PIN_OUT,
	output logic FOURTH_PORT_BIDIR_PIN_OE_OUT,
	input wire logic FOURTH_PORT_INPUT_PIN_IN,
	output logic FOURTH_PORT_INPUT_PIN_SYNC_OUT,
	// Mask option settings
	input wire logic KEYSCAN_ENABLE_IN,
	// Serial port takeover
	input wire logic SERIAL_ENABLE_BIT_IN,
	input wire logic SERIAL_MASTER_IN,
	input wire logic SERIAL_OUT_IN,
	input wire logic SERIAL_CLK_IN,
	output logic SERIAL_IN_OUT,
	output logic SERIAL_CLK_PIN_OUT,
	// Converter takeover
	input wire logic CONVERTER_ON_BIT_IN,
	output logic [7:0] CONVERTER_INPUTS_OUT,
	// Keyscan interrupt request, low active like the external pin
	output logic KEYSCAN_IRQ_N_OUT
);
	import gpio_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] dat_a;
		logic [7:0] dat_b;
		logic [7:0] dat_c;
		logic [7:0] dat_d;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] dir_d;
		logic [7:0] s1_a;
		logic [7:0] s2_a;
		logic [7:0] s1_b;
		logic [7:0] s2_b;
		logic [7:0] s1_c;
		logic [7:0] s2_c;
		logic [1:0] s1_d;
		logic [1:0] s2_d;
		logic [7:0] rdata;
		// Checker aid only: set once the first port latch holds a value.
		logic ld_a;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [7:0] pin_b_eff;
	logic [7:0] pin_d_eff;
	logic [7:0] rd_val;

	// ----------------------------------------------------------------
	// Read value
	// ----------------------------------------------------------------
	// Pins are read only after the two-stage synchroniser.
	always_comb begin
		pin_b_eff = st_r.s2_b & SECOND_PORT_MASK;
		pin_d_eff = READ_IDLE;
		pin_d_eff[FOURTH_BIDIR_BIT] = st_r.s2_d[0];
		pin_d_eff[FOURTH_INPUT_BIT] = st_r.s2_d[1];
		rd_val = READ_IDLE;
		if (ADDR_IN == FIRST_PORT_DATA_OFS) begin
			rd_val = (st_r.dat_a & st_r.dir_a) | (st_r.s2_a & ~st_r.dir_a);
		end else if (ADDR_IN == SECOND_PORT_DATA_OFS) begin
			rd_val = ((st_r.dat_b & st_r.dir_b) | (pin_b_eff & ~st_r.dir_b))
				& SECOND_PORT_MASK;
		end else if (ADDR_IN == THIRD_PORT_DATA_OFS) begin
			rd_val = (st_r.dat_c & st_r.dir_c) | (st_r.s2_c & ~st_r.dir_c);
		end else if (ADDR_IN == FOURTH_PORT_DATA_OFS) begin
			rd_val = ((st_r.dat_d & st_r.dir_d) | (pin_d_eff & ~st_r.dir_d))
				& FOURTH_READ_MASK;
		end else if (ADDR_IN == FIRST_PORT_DIRECTION_OFS) begin
			rd_val = st_r.dir_a;
		end else if (ADDR_IN == SECOND_PORT_DIRECTION_OFS) begin
			rd_val = st_r.dir_b;
		end else if (ADDR_IN == THIRD_PORT_DIRECTION_OFS) begin
			rd_val = st_r.dir_c;
		end else if (ADDR_IN == FOURTH_PORT_DIRECTION_OFS) begin
			rd_val = st_r.dir_d;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1_a = FIRST_PORT_PINS_IN;
		st_nxt.s2_a = st_r.s1_a;
		st_nxt.s1_b = SECOND_PORT_PINS_IN;
		st_nxt.s2_b = st_r.s1_b;
		st_nxt.s1_c = THIRD_PORT_PINS_IN;
		st_nxt.s2_c = st_r.s1_c;
		st_nxt.s1_d = {FOURTH_PORT_INPUT_PIN_IN, FOURTH_PORT_BIDIR_PIN_IN};
		st_nxt.s2_d = st_r.s1_d;
		st_nxt.rdata = RD_IN ? rd_val : READ_IDLE;
		// Unknown until the first write, so the latch check stays quiet before then.
		st_nxt.ld_a = st_r.ld_a | (WR_IN && ADDR_IN == FIRST_PORT_DATA_OFS);
		// Writes hit the latch regardless of direction, input pins stay untouched.
		if (WR_IN) begin
			if (ADDR_IN == FIRST_PORT_DATA_OFS) begin
				st_nxt.dat_a = WDATA_IN;
			end else if (ADDR_IN == SECOND_PORT_DATA_OFS) begin
				st_nxt.dat_b = WDATA_IN & SECOND_PORT_MASK;
			end else if (ADDR_IN == THIRD_PORT_DATA_OFS) begin
				st_nxt.dat_c = WDATA_IN;
			end else if (ADDR_IN == FOURTH_PORT_DATA_OFS) begin
				st_nxt.dat_d = WDATA_IN & FOURTH_DIR_MASK;
			end else if (ADDR_IN == FIRST_PORT_DIRECTION_OFS) begin
				st_nxt.dir_a = WDATA_IN;
			end else if (ADDR_IN == SECOND_PORT_DIRECTION_OFS) begin
				st_nxt.dir_b = WDATA_IN & SECOND_PORT_MASK;
			end else if (ADDR_IN == THIRD_PORT_DIRECTION_OFS) begin
				st_nxt.dir_c = WDATA_IN;
			end else if (ADDR_IN == FOURTH_PORT_DIRECTION_OFS) begin
				st_nxt.dir_d = WDATA_IN & FOURTH_DIR_MASK;
			end
		end
		// While the serial port runs and no register write is under way, the received bit lands in the latch,
		// which is how it modifies the second port contents.
		if (SERIAL_ENABLE_BIT_IN && !WR_IN) begin
			st_nxt.dat_b[SERIAL_IN_BIT] = st_r.s2_b[SERIAL_IN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Data latches are deliberately left out of the reset.
	always_ff @(posedge CLK_IN) begin
		st_r <= st_nxt;
		if (RST_IN) begin
			st_r.dir_a <= DIRECTION_RESET;
			st_r.dir_b <= DIRECTION_RESET;
			st_r.dir_c <= DIRECTION_RESET;
			st_r.dir_d <= DIRECTION_RESET;
			st_r.rdata <= READ_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_comb begin
		FIRST_PORT_PINS_OUT = st_r.dat_a;
		FIRST_PORT_PINS_OE_OUT = st_r.dir_a;
		FIRST_PORT_PULLUP_OUT = KEYSCAN_ENABLE_IN ? ~st_r.dir_a : 8'h00;
		SECOND_PORT_PINS_OUT = st_r.dat_b;
		SECOND_PORT_PINS_OE_OUT = st_r.dir_b;
		if (SERIAL_ENABLE_BIT_IN) begin
			SECOND_PORT_PINS_OUT[SERIAL_OUT_BIT] = SERIAL_OUT_IN;
			SECOND_PORT_PINS_OE_OUT[SERIAL_OUT_BIT] = 1'b1;
			SECOND_PORT_PINS_OE_OUT[SERIAL_IN_BIT] = 1'b0;
			SECOND_PORT_PINS_OUT[SERIAL_CLK_BIT] = SERIAL_CLK_IN;
			SECOND_PORT_PINS_OE_OUT[SERIAL_CLK_BIT] = SERIAL_MASTER_IN;
		end
		THIRD_PORT_PINS_OUT = st_r.dat_c;
		THIRD_PORT_PINS_OE_OUT = st_r.dir_c;
		// The converter needs its pins floating; the latch still holds.
		if (CONVERTER_ON_BIT_IN) begin
			THIRD_PORT_PINS_OE_OUT = st_r.dir_c & ~CONVERTER_PIN_MASK;
		end
		FOURTH_PORT_BIDIR_PIN_OUT = st_r.dat_d[FOURTH_BIDIR_BIT];
		FOURTH_PORT_BIDIR_PIN_OE_OUT = st_r.dir_d[FOURTH_BIDIR_BIT];
	end

	// ----------------------------------------------------------------
	// Shared-function outputs
	// ----------------------------------------------------------------
	assign RDATA_OUT = st_r.rdata;
	assign FOURTH_PORT_INPUT_PIN_SYNC_OUT = st_r.s2_d[1];
	assign SERIAL_IN_OUT = st_r.s2_b[SERIAL_IN_BIT];
	assign SERIAL_CLK_PIN_OUT = st_r.s2_b[SERIAL_CLK_BIT];
	assign CONVERTER_INPUTS_OUT = CONVERTER_ON_BIT_IN ? (st_r.s2_c & CONVERTER_PIN_MASK) : 8'h00;
	// Any low first-port input pin pulls the request low, as the external pin would.
	assign KEYSCAN_IRQ_N_OUT = !(KEYSCAN_ENABLE_IN && |(~st_r.s2_a & ~st_r.dir_a));

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_DIR_RESET: assert property (@(posedge CLK_IN) RST_IN |=>
		(FIRST_PORT_PINS_OE_OUT == 8'h00 && THIRD_PORT_PINS_OE_OUT == 8'h00))
		else $error("Direction not cleared by reset");
	AST_LATCH_KEEP: assert property (@(posedge CLK_IN) st_r.ld_a && RST_IN && !WR_IN |=>
		FIRST_PORT_PINS_OUT == $past(FIRST_PORT_PINS_OUT))
		else $error("Reset changed a data latch");
	AST_DRIVE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == FIRST_PORT_DIRECTION_OFS |=> FIRST_PORT_PINS_OE_OUT == $past(WDATA_IN))
		else $error("Drive enable does not follow direction");
	AST_READ_OUT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		RD_IN && ADDR_IN == 4'h0 && FIRST_PORT_PINS_OE_OUT == 8'hFF
		|=> RDATA_OUT == $past(FIRST_PORT_PINS_OUT))
		else $error("Output read does not return latch");
	AST_WRITE_LATCH: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == 4'h2 |=> THIRD_PORT_PINS_OUT == $past(WDATA_IN))
		else $error("Data write not latched");
	AST_DIR_RB: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == 4'h4 ##1 RD_IN && ADDR_IN == 4'h4 && !$past(RST_IN)
		|=> RDATA_OUT == $past(WDATA_IN, 2))
		else $error("Direction read-back wrong");
	AST_UNIMPL: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$past(RD_IN) && $past(ADDR_IN) == 4'h3 |-> (RDATA_OUT & 8'h5F) == 8'h00)
		else $error("Unimplemented bits not zero");
	AST_SERIAL_OUT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SERIAL_ENABLE_BIT_IN |-> SECOND_PORT_PINS_OE_OUT[5] && !SECOND_PORT_PINS_OE_OUT[6])
		else $error("Serial pin takeover wrong");
	AST_CONV: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CONVERTER_ON_BIT_IN |-> (THIRD_PORT_PINS_OE_OUT & 8'hF8) == 8'h00)
		else $error("Converter pins driven");
	AST_KEYSCAN: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!KEYSCAN_ENABLE_IN |-> KEYSCAN_IRQ_N_OUT)
		else $error("Keyscan request without option");

	// ----------------------------------------------------------------
	// Reset checks
	// ----------------------------------------------------------------
	// The serial port may own bits 5 and 7 right after reset, so that case is left out.
	AST_DIR_RESET_BD: assert property (@(posedge CLK_IN)
		RST_IN ##1 !SERIAL_ENABLE_BIT_IN |->
		(SECOND_PORT_PINS_OE_OUT == 8'h00 && !FOURTH_PORT_BIDIR_PIN_OE_OUT))
		else $error("Second or fourth port direction not cleared by reset");

	// ----------------------------------------------------------------
	// Register port checks
	// ----------------------------------------------------------------
	AST_RDATA_IDLE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!RD_IN |=> RDATA_OUT == READ_IDLE)
		else $error("Read data not idle outside a read");

	AST_WR_A: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == FIRST_PORT_DATA_OFS |=> FIRST_PORT_PINS_OUT == $past(WDATA_IN))
		else $error("First port latch not written");

	AST_WR_B: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!SERIAL_ENABLE_BIT_IN && WR_IN && ADDR_IN == SECOND_PORT_DATA_OFS ##1 !SERIAL_ENABLE_BIT_IN
		|-> SECOND_PORT_PINS_OUT == ($past(WDATA_IN) & SECOND_PORT_MASK))
		else $error("Second port latch not written");

	AST_WR_D: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == FOURTH_PORT_DATA_OFS |=> FOURTH_PORT_BIDIR_PIN_OUT == $past(WDATA_IN[5]))
		else $error("Fourth port latch not written");

	AST_OE_B: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!SERIAL_ENABLE_BIT_IN && WR_IN && ADDR_IN == SECOND_PORT_DIRECTION_OFS
		##1 !SERIAL_ENABLE_BIT_IN |-> SECOND_PORT_PINS_OE_OUT == ($past(WDATA_IN) & SECOND_PORT_MASK))
		else $error("Second port drive does not follow direction");

	AST_OE_C: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!CONVERTER_ON_BIT_IN && WR_IN && ADDR_IN == THIRD_PORT_DIRECTION_OFS
		##1 !CONVERTER_ON_BIT_IN |-> THIRD_PORT_PINS_OE_OUT == $past(WDATA_IN))
		else $error("Third port drive does not follow direction");

	AST_OE_D: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == FOURTH_PORT_DIRECTION_OFS
		|=> FOURTH_PORT_BIDIR_PIN_OE_OUT == $past(WDATA_IN[5]))
		else $error("Fourth port drive does not follow direction");

	AST_DIR_B_RB: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == SECOND_PORT_DIRECTION_OFS ##1 RD_IN && ADDR_IN == SECOND_PORT_DIRECTION_OFS
		|=> RDATA_OUT == ($past(WDATA_IN, 2) & SECOND_PORT_MASK))
		else $error("Second port direction read-back wrong");

	AST_DIR_D_RB: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		WR_IN && ADDR_IN == FOURTH_PORT_DIRECTION_OFS ##1 RD_IN && ADDR_IN == FOURTH_PORT_DIRECTION_OFS
		|=> RDATA_OUT == ($past(WDATA_IN, 2) & FOURTH_DIR_MASK))
		else $error("Fourth port direction read-back wrong");

	AST_UNIMPL_B: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$past(RD_IN) && $past(ADDR_IN) == SECOND_PORT_DATA_OFS |-> (RDATA_OUT & ~SECOND_PORT_MASK) == 8'h00)
		else $error("Second port unimplemented bits not zero");

	// Indices 8 to 15 decode to nothing and must read back as idle.
	AST_UNMAPPED: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$past(RD_IN) && $past(ADDR_IN[3]) |-> RDATA_OUT == READ_IDLE)
		else $error("Unmapped index returned data");

	// ----------------------------------------------------------------
	// Shared pin checks
	// ----------------------------------------------------------------
	AST_SERIAL_DATA: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SERIAL_ENABLE_BIT_IN |-> SECOND_PORT_PINS_OUT[SERIAL_OUT_BIT] == SERIAL_OUT_IN)
		else $error("Serial data not on bit five");

	AST_SERIAL_CLK: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SERIAL_ENABLE_BIT_IN |-> SECOND_PORT_PINS_OE_OUT[SERIAL_CLK_BIT] == SERIAL_MASTER_IN)
		else $error("Serial clock direction wrong");

	// Both serial inputs pass the same two-stage synchroniser as the port read.
	AST_SERIAL_IN: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SERIAL_IN_OUT == $past(SECOND_PORT_PINS_IN[SERIAL_IN_BIT], 2))
		else $error("Serial data input not synchronised");

	AST_SERIAL_CLK_IN: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SERIAL_CLK_PIN_OUT == $past(SECOND_PORT_PINS_IN[SERIAL_CLK_BIT], 2))
		else $error("Serial clock input not synchronised");

	AST_PULLUP_ON: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		KEYSCAN_ENABLE_IN |-> FIRST_PORT_PULLUP_OUT == ~FIRST_PORT_PINS_OE_OUT)
		else $error("Pull-up missing on keyscan input");

	AST_PULLUP_OFF: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!KEYSCAN_ENABLE_IN |-> FIRST_PORT_PULLUP_OUT == 8'h00)
		else $error("Pull-up on without keyscan option");

	AST_INPUT_SYNC: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		FOURTH_PORT_INPUT_PIN_SYNC_OUT == $past(FOURTH_PORT_INPUT_PIN_IN, 2))
		else $error("Input-only pin not synchronised");

	AST_CONV_IN: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CONVERTER_ON_BIT_IN |-> (CONVERTER_INPUTS_OUT & ~CONVERTER_PIN_MASK) == 8'h00)
		else $error("Converter sees a plain port pin");

	AST_CONV_OFF: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!CONVERTER_ON_BIT_IN |-> CONVERTER_INPUTS_OUT == 8'h00)
		else $error("Converter inputs live while off");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	CVR_CONV: cover property (@(posedge CLK_IN) CONVERTER_ON_BIT_IN && THIRD_PORT_PINS_OE_OUT != 8'h00);
	CVR_SERIAL: cover property (@(posedge CLK_IN) SERIAL_ENABLE_BIT_IN && SERIAL_MASTER_IN);
	CVR_KEY: cover property (@(posedge CLK_IN) !KEYSCAN_IRQ_N_OUT);
	CVR_WR_RD: cover property (@(posedge CLK_IN) WR_IN ##1 RD_IN);

endmodule // four_port_parallel_io

//--- design/gpio_pkg.sv
/*
 * Package for the four-port parallel I/O bank: register offsets, field
 * positions, implemented-bit masks and reset values.
 * Assumes a byte-wide register port with addresses 0x0 to 0xF.
 */
package gpio_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] FIRST_PORT_DATA_OFS = 4'h0;
	localparam logic [3:0] SECOND_PORT_DATA_OFS = 4'h1;
	localparam logic [3:0] THIRD_PORT_DATA_OFS = 4'h2;
	localparam logic [3:0] FOURTH_PORT_DATA_OFS = 4'h3;
	localparam logic [3:0] FIRST_PORT_DIRECTION_OFS = 4'h4;
	localparam logic [3:0] SECOND_PORT_DIRECTION_OFS = 4'h5;
	localparam logic [3:0] THIRD_PORT_DIRECTION_OFS = 4'h6;
	localparam logic [3:0] FOURTH_PORT_DIRECTION_OFS = 4'h7;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] SECOND_PORT_MASK = 8'hE0;
	localparam logic [7:0] FOURTH_DIR_MASK = 8'h20;
	localparam logic [7:0] FOURTH_READ_MASK = 8'hA0;
	localparam logic [7:0] CONVERTER_PIN_MASK = 8'hF8;
	localparam int SERIAL_OUT_BIT = 5;
	localparam int SERIAL_IN_BIT = 6;
	localparam int SERIAL_CLK_BIT = 7;
	localparam int FOURTH_BIDIR_BIT = 5;
	localparam int FOURTH_INPUT_BIT = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

//--- testbench/board_model.sv
/*
 * Board-side model of one eight-line port: each line shows the device's
 * value where the device drives it and the board's value elsewhere.
 * Assumes the board always drives every undriven line to a known level.
 */
`timescale 1ns/1ps
module board_model (
	// Device side
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	// Board side
	input wire logic [7:0] board_in,
	output logic [7:0] level_out
);
	assign level_out = (oe_in & drv_in) | (~oe_in & board_in);
endmodule // board_model

//--- testbench/tb_top.sv
/*
 * Self-checking bench for the four-port parallel I/O bank.
 * Assumes the register port answers reads in the following cycle.
 */
`timescale 1ns/1ps
module tb_top;
	import gpio_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, ks = 0, se = 0, sm = 0, so = 0, sc = 0, con = 0;
	logic b4 = 0, b7 = 0, o4, e4, p4s, sin, sclk, irq_n;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, b1 = 8'h00, b2 = 8'h00, b3 = 8'h00, p1, p2, p3;
	logic [7:0] o1, e1, pu1, o2, e2, o3, e3, cin, v;
	int miscompares = 0, n_checks = 0, cyc = 0;
	wire p4 = e4 ? o4 : b4;
	board_model bm1 (.drv_in(o1), .oe_in(e1), .board_in(b1), .level_out(p1));
	board_model bm2 (.drv_in(o2), .oe_in(e2), .board_in(b2), .level_out(p2));
	board_model bm3 (.drv_in(o3), .oe_in(e3), .board_in(b3), .level_out(p3));
	four_port_parallel_io dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .FIRST_PORT_PINS_IN(p1),
		.FIRST_PORT_PINS_OUT(o1), .FIRST_PORT_PINS_OE_OUT(e1), .FIRST_PORT_PULLUP_OUT(pu1),
		.SECOND_PORT_PINS_IN(p2), .SECOND_PORT_PINS_OUT(o2), .SECOND_PORT_PINS_OE_OUT(e2),
		.THIRD_PORT_PINS_IN(p3), .THIRD_PORT_PINS_OUT(o3), .THIRD_PORT_PINS_OE_OUT(e3),
		.FOURTH_PORT_BIDIR_PIN_IN(p4), .FOURTH_PORT_BIDIR_PIN_OUT(o4),
		.FOURTH_PORT_BIDIR_PIN_OE_OUT(e4), .FOURTH_PORT_INPUT_PIN_IN(b7),
		.FOURTH_PORT_INPUT_PIN_SYNC_OUT(p4s), .KEYSCAN_ENABLE_IN(ks),
		.SERIAL_ENABLE_BIT_IN(se), .SERIAL_MASTER_IN(sm), .SERIAL_OUT_IN(so),
		.SERIAL_CLK_IN(sc), .SERIAL_IN_OUT(sin), .SERIAL_CLK_PIN_OUT(sclk),
		.CONVERTER_ON_BIT_IN(con), .CONVERTER_INPUTS_OUT(cin), .KEYSCAN_IRQ_N_OUT(irq_n));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			results();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		for (int i = 4; i < 8; i++) rd_chk(i[3:0], DIRECTION_RESET);
		check(e1 | e2 | e3, 8'h00);
		wr_reg(FIRST_PORT_DATA_OFS, 8'h5A);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		wr_reg(FIRST_PORT_DIRECTION_OFS, 8'hFF);
		#1 check(o1, 8'h5A);
		$display("reset test done");
	endtask
	task automatic t_outputs();
		logic [7:0] dm [4] = '{8'hFF, 8'hE0, 8'hFF, 8'h20};
		for (int i = 0; i < 4; i++) begin
			v = 8'hA5 ^ i[7:0];
			wr_reg(i[3:0], v);
			wr_reg(i[3:0] + 4'h4, 8'hFF);
			rd_chk(i[3:0], v & dm[i]);
			rd_chk(i[3:0] + 4'h4, dm[i]);
		end
		check(o1, 8'hA5);
		check(e2, 8'hE0);
		check(o2 & 8'hE0, 8'hA4 & 8'hE0);
		check(o3, 8'hA7);
		check({6'h0, e4, o4}, 8'h03);
		rd_chk(4'h9, READ_IDLE);
		$display("output test done");
	endtask
	task automatic t_inputs();
		b1 <= 8'h3C;
		b2 <= 8'hA0;
		b3 <= 8'hC3;
		b4 <= 1'b1;
		b7 <= 1'b1;
		for (int i = 0; i < 4; i++) wr_reg(i[3:0] + 4'h4, 8'h00);
		for (int i = 0; i < 4; i++) wr_reg(i[3:0], 8'h00);
		wr_reg(4'h9, 8'hFF);
		settle();
		check(e1 | e2 | e3, 8'h00);
		rd_chk(FIRST_PORT_DATA_OFS, 8'h3C);
		rd_chk(SECOND_PORT_DATA_OFS, 8'hA0);
		rd_chk(THIRD_PORT_DATA_OFS, 8'hC3);
		rd_chk(FOURTH_PORT_DATA_OFS, 8'hA0);
		check({7'h0, p4s}, 8'h01);
		wr_reg(FIRST_PORT_DIRECTION_OFS, 8'h0F);
		rd_chk(FIRST_PORT_DATA_OFS, 8'h30);
		check(o1, 8'h00);
		$display("input test done");
	endtask
	task automatic t_shared();
		wr_reg(SECOND_PORT_DIRECTION_OFS, 8'h20);
		se <= 1'b1;
		sm <= 1'b1;
		so <= 1'b1;
		b2 <= 8'h40;
		settle();
		check({e2[7:5], o2[5], sin}, 8'h17);
		rd_chk(SECOND_PORT_DIRECTION_OFS, 8'h20);
		sm <= 1'b0;
		b2 <= 8'h80;
		settle();
		check({e2[7], sclk}, 8'h01);
		se <= 1'b0;
		settle();
		check(e2, 8'h20);
		wr_reg(THIRD_PORT_DIRECTION_OFS, 8'hFF);
		con <= 1'b1;
		settle();
		check(e3, 8'h07);
		check(cin, 8'hC0);
		con <= 1'b0;
		settle();
		check(e3, 8'hFF);
		$display("shared pin test done");
	endtask
	task automatic t_keyscan();
		ks <= 1'b1;
		b1 <= 8'hFF;
		wr_reg(FIRST_PORT_DIRECTION_OFS, 8'h00);
		settle();
		check({pu1}, 8'hFF);
		check({7'h0, irq_n}, 8'h01);
		b1 <= 8'hFE;
		settle();
		check({7'h0, irq_n}, 8'h00);
		wr_reg(FIRST_PORT_DIRECTION_OFS, 8'h01);
		settle();
		check({pu1[7:1], irq_n}, 8'hFF);
		ks <= 1'b0;
		settle();
		check(pu1, 8'h00);
		$display("keyscan test done");
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_outputs();
		t_inputs();
		t_shared();
		t_keyscan();
		results();
	end
endmodule // tb_top
